// ===== common/ccr_pkg.sv
package ccr_pkg;
    // Byte addresses: printed offsets are not all multiples of four, so address = 4 * index
    localparam logic [7:0] IDX_BLOCK_CTRL = 8'h08;
    localparam logic [7:0] IDX_IFACE = 8'h09;
    localparam logic [7:0] IDX_OFF_LOW = 8'h0b;
    localparam logic [7:0] IDX_OFF_HIGH = 8'h0c;
    localparam logic [7:0] IDX_ON_TIME = 8'h0d;
    localparam logic [7:0] IDX_ADC_REF = 8'h0e;
    localparam logic [7:0] IDX_DAC_REF = 8'h0f;
    localparam logic [7:0] IDX_STATUS = 8'h10;
    localparam int ADDR_W = 8;
    localparam int IDX_LSB = 2;

    // Block control fields
    localparam int BIT_DAC_OFF = 3;
    localparam int BIT_ADC_OFF = 2;
    localparam int DIV_LSB = 0;
    localparam logic [7:0] BLOCK_RST = 8'h00;
    localparam logic [7:0] BLOCK_RSV_MASK = 8'h0f;

    // Interface fields
    localparam int BIT_LOOP = 7;
    localparam int BIT_RX_SEL = 6;
    localparam int BIT_RSV5 = 5;
    localparam int BIT_MASTER = 4;
    localparam int BIT_FLOAT = 3;
    localparam int BIT_TX_FIRST = 2;
    localparam int BIT_TX_SECOND = 1;
    localparam int BIT_PROTO = 0;
    localparam logic [7:0] IFACE_RST = 8'h24;
    localparam logic [7:0] IFACE_RSV_SET = 8'h20;

    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] DIV_BY1 = 2'b00;
    localparam logic [1:0] DIV_BY2 = 2'b01;
    localparam logic [1:0] DIV_BY4 = 2'b11;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// ===== design/ccr_top.sv
`timescale 1ns/1ps
// How it works
// - DAC path bit set powers down converter and power amp outputs.
// - ADC path bit set shuts preamp, converter and decimator.
// - Divider code selects master clock division by one, two or four.
// - Slave-select pin at startup sets divider default, low gives 01.
// - Return-path bit routes ADC samples into the DAC input.
// - Receive select picks first or second 16-bit slot after sync.
// - Master bit selects master role, allowed only with long sync.
// - Float bit clear drives serial output through both slots.
// - Float bit set releases output in slots not enabled to send.
// - First-slot transmit enable sends ADC sample in first slot.
// - Second-slot transmit enable sends ADC sample in second slot.
// - Protocol bit: one short sync slave only, zero long sync.
// - Serial clock pin at startup sets protocol default, low gives 1.
// - Off-time is one 16-bit value from low and high byte registers.
// - On-time comes from its 8-bit register, reset zero.
// - ADC activity reference comes from its 8-bit register.
// - DAC activity reference comes from its 8-bit register.
// - All registers are 8 bits and reset to defaults.
module ccr_top
    import ccr_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic STRAP_SS,
    input wire logic STRAP_SCK,
    input wire logic FRAME_SYNC,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic DAC_POWER_DOWN,
    output logic ADC_POWER_DOWN,
    output logic [1:0] MASTER_CLOCK_DIVIDER,
    output logic LOOPBACK_EN,
    output logic RX_SECOND_SLOT,
    output logic MASTER_MODE,
    output logic SHORT_FRAME_SYNC,
    output logic SLOT1_OE,
    output logic SLOT2_OE,
    output logic SLOT1_TX,
    output logic SLOT2_TX,
    output logic [15:0] SLEEP_OFF_TIME,
    output logic [7:0] SLEEP_ON_TIME,
    output logic [7:0] ADC_ACTIVITY_REFERENCE,
    output logic [7:0] DAC_ACTIVITY_REFERENCE
);

    // ==========================================================
    // Reset release and pin synchronisers
    // ==========================================================
    logic rst_meta_ff;
    logic rst_n_ff;
    logic ss_meta_ff, ss_sync_ff;
    logic sck_meta_ff, sck_sync_ff;
    logic fs_meta_ff, fs_sync_ff, fs_prev_ff;
    logic strap_done_ff;

    // Asynchronous assert, synchronous release
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Pins cross from outside, two stages each
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ss_meta_ff <= 1'b0;
            ss_sync_ff <= 1'b0;
            sck_meta_ff <= 1'b0;
            sck_sync_ff <= 1'b0;
            fs_meta_ff <= 1'b0;
            fs_sync_ff <= 1'b0;
            fs_prev_ff <= 1'b0;
        end else begin
            ss_meta_ff <= STRAP_SS;
            ss_sync_ff <= ss_meta_ff;
            sck_meta_ff <= STRAP_SCK;
            sck_sync_ff <= sck_meta_ff;
            fs_meta_ff <= FRAME_SYNC;
            fs_sync_ff <= fs_meta_ff;
            fs_prev_ff <= fs_sync_ff;
        end
    end

    wire fs_rise = fs_sync_ff & ~fs_prev_ff;

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    logic aw_held_ff, w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic wstb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic awready_ff, wready_ff, arready_ff;
    logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid;
    logic [7:0] block_ff, iface_ff, off_lo_ff, off_hi_ff, on_ff, adref_ff, daref_ff;
    logic [7:0] rd_byte;
    logic rd_hit;

    // Word index of a byte address, or all ones when misaligned
    function automatic logic [7:0] reg_index(input logic [7:0] addr);
        logic [7:0] idx;
        idx = {2'b00, addr[ADDR_W-1:IDX_LSB]};
        if (addr[IDX_LSB-1:0] != 2'b00) begin
            idx = 8'hff;
        end
        return idx;
    endfunction

    wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire [7:0] wr_idx = reg_index(awaddr_ff);
    wire [7:0] wr_byte = wdata_ff[7:0];
    wire wr_known = (wr_idx == IDX_BLOCK_CTRL) | (wr_idx == IDX_IFACE) |
                    (wr_idx == IDX_OFF_LOW) | (wr_idx == IDX_OFF_HIGH) |
                    (wr_idx == IDX_ON_TIME) | (wr_idx == IDX_ADC_REF) |
                    (wr_idx == IDX_DAC_REF);
    wire wr_en = do_write & wstb_ff & wr_known;

    // Address and data are captured independently, in any order
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= WORD_ZERO;
            wstb_ff <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstb_ff <= S_AXI_WSTRB[0];
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read mux, reserved bits come back as stored defaults
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (reg_index(S_AXI_ARADDR))
            IDX_BLOCK_CTRL: rd_byte = block_ff;
            IDX_IFACE: rd_byte = iface_ff;
            IDX_OFF_LOW: rd_byte = off_lo_ff;
            IDX_OFF_HIGH: rd_byte = off_hi_ff;
            IDX_ON_TIME: rd_byte = on_ff;
            IDX_ADC_REF: rd_byte = adref_ff;
            IDX_DAC_REF: rd_byte = daref_ff;
            IDX_STATUS: rd_byte = {4'h0, SLOT2_TX, SLOT1_TX, SLOT2_OE, SLOT1_OE};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read answer, held until taken
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= WORD_ZERO;
            rresp_ff <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;

    // ==========================================================
    // Registered readys
    // ==========================================================
    // Next holding state; readys are flops, so they must look one edge ahead
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_bvalid = bvalid_ff;
        nxt_rvalid = rvalid_ff;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            nxt_aw_held = 1'b1;
        end else if (do_write) begin
            nxt_aw_held = 1'b0;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            nxt_w_held = 1'b1;
        end else if (do_write) begin
            nxt_w_held = 1'b0;
        end
        if (do_write) begin
            nxt_bvalid = 1'b1;
        end else if (S_AXI_BREADY) begin
            nxt_bvalid = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            nxt_rvalid = 1'b1;
        end else if (S_AXI_RREADY) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Low in reset and while a stage is full or an answer waits
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            arready_ff <= 1'b0;
        end else begin
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff <= ~nxt_w_held & ~nxt_bvalid;
            arready_ff <= ~nxt_rvalid;
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_ARREADY = arready_ff;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    // Straps are caught once the synchronisers hold the pin level
    // One stage earlier would read the synchroniser reset value, not the pin
    logic strap_wait_ff;
    logic strap_ready_ff;
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            strap_wait_ff <= 1'b0;
            strap_ready_ff <= 1'b0;
            strap_done_ff <= 1'b0;
        end else begin
            strap_wait_ff <= 1'b1;
            strap_ready_ff <= strap_wait_ff;
            strap_done_ff <= strap_ready_ff;
        end
    end
    wire strap_take = strap_ready_ff & ~strap_done_ff;

    // Block control; a reserved code 10 is stored as written
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            block_ff <= BLOCK_RST;
        end else if (strap_take) begin
            block_ff[DIV_LSB+1:DIV_LSB] <= ss_sync_ff ? DIV_BY1 : DIV_BY2;
        end else if (wr_en && wr_idx == IDX_BLOCK_CTRL) begin
            block_ff <= wr_byte & BLOCK_RSV_MASK;
        end
    end

    // Interface setup; bit 5 always reads one
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            iface_ff <= IFACE_RST;
        end else if (strap_take) begin
            iface_ff[BIT_PROTO] <= ~sck_sync_ff;
        end else if (wr_en && wr_idx == IDX_IFACE) begin
            iface_ff <= wr_byte | IFACE_RSV_SET;
        end
    end

    // Sleep-function bytes
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            off_lo_ff <= BYTE_RST;
            off_hi_ff <= BYTE_RST;
            on_ff <= BYTE_RST;
            adref_ff <= BYTE_RST;
            daref_ff <= BYTE_RST;
        end else if (wr_en) begin
            if (wr_idx == IDX_OFF_LOW) off_lo_ff <= wr_byte;
            if (wr_idx == IDX_OFF_HIGH) off_hi_ff <= wr_byte;
            if (wr_idx == IDX_ON_TIME) on_ff <= wr_byte;
            if (wr_idx == IDX_ADC_REF) adref_ff <= wr_byte;
            if (wr_idx == IDX_DAC_REF) daref_ff <= wr_byte;
        end
    end

    // ==========================================================
    // Control outputs, registered
    // ==========================================================
    // Master only honoured with long sync, so a bad combination falls back to slave
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            DAC_POWER_DOWN <= 1'b0;
            ADC_POWER_DOWN <= 1'b0;
            MASTER_CLOCK_DIVIDER <= DIV_BY1;
            LOOPBACK_EN <= 1'b0;
            MASTER_MODE <= 1'b0;
            SHORT_FRAME_SYNC <= 1'b0;
            SLEEP_OFF_TIME <= 16'h0000;
            SLEEP_ON_TIME <= BYTE_RST;
            ADC_ACTIVITY_REFERENCE <= BYTE_RST;
            DAC_ACTIVITY_REFERENCE <= BYTE_RST;
        end else begin
            DAC_POWER_DOWN <= block_ff[BIT_DAC_OFF];
            ADC_POWER_DOWN <= block_ff[BIT_ADC_OFF];
            MASTER_CLOCK_DIVIDER <= block_ff[DIV_LSB+1:DIV_LSB];
            LOOPBACK_EN <= iface_ff[BIT_LOOP];
            MASTER_MODE <= iface_ff[BIT_MASTER] & ~iface_ff[BIT_PROTO];
            SHORT_FRAME_SYNC <= iface_ff[BIT_PROTO];
            SLEEP_OFF_TIME <= {off_hi_ff, off_lo_ff};
            SLEEP_ON_TIME <= on_ff;
            ADC_ACTIVITY_REFERENCE <= adref_ff;
            DAC_ACTIVITY_REFERENCE <= daref_ff;
        end
    end

    // Slot settings latch at frame sync so no slot is split
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            RX_SECOND_SLOT <= 1'b0;
            SLOT1_TX <= 1'b1;
            SLOT2_TX <= 1'b0;
            SLOT1_OE <= 1'b1;
            SLOT2_OE <= 1'b1;
        end else if (fs_rise) begin
            RX_SECOND_SLOT <= iface_ff[BIT_RX_SEL];
            SLOT1_TX <= iface_ff[BIT_TX_FIRST];
            SLOT2_TX <= iface_ff[BIT_TX_SECOND];
            // Drive always when float is off, else only in sending slots
            SLOT1_OE <= ~iface_ff[BIT_FLOAT] | iface_ff[BIT_TX_FIRST];
            SLOT2_OE <= ~iface_ff[BIT_FLOAT] | iface_ff[BIT_TX_SECOND];
        end
    end

endmodule // ccr_top

// ===== testbench/ccr_monitor.sv
`timescale 1ns/1ps
// ==========
// Pin checker
module ccr_monitor (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic FRAME_SYNC,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic MASTER_MODE,
    input wire logic SHORT_FRAME_SYNC,
    input wire logic SLOT1_OE,
    input wire logic SLOT2_OE,
    input wire logic SLOT1_TX,
    input wire logic SLOT2_TX
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    a_short_no_master: assert property (SHORT_FRAME_SYNC |-> !MASTER_MODE)
        else $error("master role with short sync");
    a_tx1_drives: assert property (SLOT1_TX |-> SLOT1_OE)
        else $error("first slot sent undriven");
    a_tx2_drives: assert property (SLOT2_TX |-> SLOT2_OE)
        else $error("second slot sent undriven");
    // Slot settings only move a few edges after a sync pulse
    a_slot_at_sync: assert property (
        $changed({SLOT1_TX, SLOT2_TX, SLOT1_OE, SLOT2_OE})
        |-> $past(FRAME_SYNC, 3) || $past(FRAME_SYNC, 4) || $past(FRAME_SYNC, 5))
        else $error("slot setting moved outside sync");
    // Both halves sit one edge in the holding stage before the response rises
    a_write_answer: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##2 S_AXI_BVALID)
        else $error("no write response");
    a_bresp_holds: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("no read response");
    a_rdata_holds: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_byte_wide: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
        else $error("upper read bits set");
endmodule // ccr_monitor

// ===== testbench/ccr_fsync_src.sv
`timescale 1ns/1ps
// ==========
// Host side frame sync source, long pulse so the 2FF sampler sees it
module ccr_fsync_src (
    input wire logic clock,
    input wire logic trig,
    output logic frame_sync
);
    logic [3:0] cnt_ff = 4'h0;
    // One pulse per request, host stays slave-compatible
    always_ff @(posedge clock) begin
        if (trig) cnt_ff <= 4'h6;
        else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
    assign frame_sync = (cnt_ff != 4'h0) && (cnt_ff < 4'h5);
endmodule // ccr_fsync_src

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    logic CLOCK = 0, RESETN = 0, STRAP_SS = 0, STRAP_SCK = 0, FRAME_SYNC, trig = 0;
    logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_ARREADY, S_AXI_BVALID, S_AXI_RVALID, DAC_POWER_DOWN, ADC_POWER_DOWN;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 0;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, MASTER_CLOCK_DIVIDER;
    logic LOOPBACK_EN, RX_SECOND_SLOT, MASTER_MODE, SHORT_FRAME_SYNC;
    logic SLOT1_OE, SLOT2_OE, SLOT1_TX, SLOT2_TX;
    logic [15:0] SLEEP_OFF_TIME;
    logic [7:0] SLEEP_ON_TIME, ADC_ACTIVITY_REFERENCE, DAC_ACTIVITY_REFERENCE;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    logic [7:0] t_a[8] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h20, 8'h20, 8'h20};
    logic [7:0] t_d[8] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h7e, 8'hf8, 8'h07, 8'h01};
    logic [7:0] t_e[8] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h7e, 8'h08, 8'h07, 8'h01};

    ccr_top u_ccr_top (.*);
    ccr_fsync_src u_ccr_fsync_src (.clock(CLOCK), .trig(trig), .frame_sync(FRAME_SYNC));

    always #2 CLOCK = ~CLOCK;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ==========
    // Bus cycles: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h0, d};
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1;
        S_AXI_WVALID <= 1;
        S_AXI_BREADY <= 1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 0;
        chk("bresp", S_AXI_BRESP, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1;
        S_AXI_RREADY <= 1;
        do begin
            @(posedge CLOCK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 0;
        chk("rresp", S_AXI_RRESP, er);
        chk("rdata", S_AXI_RDATA, {24'h0, ed});
    endtask

    task automatic sync_pulse();
        @(posedge CLOCK);
        trig <= 1;
        @(posedge CLOCK);
        trig <= 0;
        repeat (14) @(posedge CLOCK);
    endtask

    function automatic logic [7:0] obs(input logic [7:0] a);
        case (a)
            8'h20: obs = {4'h0, DAC_POWER_DOWN, ADC_POWER_DOWN, MASTER_CLOCK_DIVIDER};
            8'h2c: obs = SLEEP_OFF_TIME[7:0];
            8'h30: obs = SLEEP_OFF_TIME[15:8];
            8'h34: obs = SLEEP_ON_TIME;
            8'h38: obs = ADC_ACTIVITY_REFERENCE;
            default: obs = DAC_ACTIVITY_REFERENCE;
        endcase
    endfunction

    // ==========
    // Main sequence
    initial begin
        repeat (20) @(posedge CLOCK);
        RESETN <= 1;
        repeat (10) @(posedge CLOCK);
        rd(8'h20, 8'h01, RESP_OKAY);
        rd(8'h24, 8'h25, RESP_OKAY);
        for (int i = 0; i < 5; i++) rd(t_a[i], 8'h00, RESP_OKAY);
        chk("sfs", SHORT_FRAME_SYNC, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(t_a[i], t_d[i], 4'hf, RESP_OKAY);
            rd(t_a[i], t_e[i], RESP_OKAY);
            chk("pins", obs(t_a[i]), t_e[i]);
        end
        // Refused and ignored accesses leave everything in place
        wr(8'h34, 8'h11, 4'h0, RESP_OKAY);
        rd(8'h34, 8'h3c, RESP_OKAY);
        wr(8'h28, 8'h11, 4'hf, RESP_SLVERR);
        rd(8'h28, 8'h00, RESP_SLVERR);
        // Slot settings wait for sync, other bits act at once
        wr(8'h24, 8'hd0, 4'hf, RESP_OKAY);
        rd(8'h24, 8'hf0, RESP_OKAY);
        chk("loop", {LOOPBACK_EN, MASTER_MODE, SHORT_FRAME_SYNC}, 3'b110);
        chk("early", {RX_SECOND_SLOT, SLOT1_TX}, 2'b01);
        sync_pulse();
        chk("slots a", {RX_SECOND_SLOT, SLOT1_TX, SLOT2_TX, SLOT1_OE, SLOT2_OE},
            5'b10011);
        wr(8'h24, 8'h0b, 4'hf, RESP_OKAY);
        sync_pulse();
        chk("slots b", {MASTER_MODE, SLOT1_TX, SLOT2_TX, SLOT1_OE, SLOT2_OE},
            5'b00101);
        wr(8'h24, 8'h1d, 4'hf, RESP_OKAY);
        sync_pulse();
        chk("slots c", {MASTER_MODE, SLOT1_TX, SLOT2_TX, SLOT1_OE, SLOT2_OE},
            5'b01010);
        // Status word mirrors the latched slots and takes no writes
        rd(8'h40, 8'h05, RESP_OKAY);
        wr(8'h40, 8'h11, 4'hf, RESP_SLVERR);
        // Second reset with both straps high picks the other defaults
        STRAP_SS <= 1;
        STRAP_SCK <= 1;
        RESETN <= 0;
        repeat (3) @(posedge CLOCK);
        chk("rst pins", {S_AXI_AWREADY, S_AXI_ARREADY, SLOT1_TX, SLOT2_TX, SLOT1_OE, SLOT2_OE,
            MASTER_CLOCK_DIVIDER, SLEEP_OFF_TIME}, {2'b00, 4'b1011, 2'b00, 16'h0000});
        RESETN <= 1;
        repeat (10) @(posedge CLOCK);
        rd(8'h20, 8'h00, RESP_OKAY);
        rd(8'h24, 8'h24, RESP_OKAY);
        rd(8'h2c, 8'h00, RESP_OKAY);
        chk("rst ctrl", {SHORT_FRAME_SYNC, MASTER_CLOCK_DIVIDER, LOOPBACK_EN}, 4'h0);
        give_verdict();
    end
endmodule // tb

bind ccr_top ccr_monitor u_ccr_monitor (.*);
